/* File: logic/bpps_defines.svh */
// Constants of the balance pin pulse sequencer: offsets, fields, timing.
// Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef BPPS_DEFINES_SVH
`define BPPS_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define BPPS_ADDR_CMD 8'h00
`define BPPS_ADDR_STG_A0 8'h04
`define BPPS_ADDR_STG_A1 8'h08
`define BPPS_ADDR_STG_B 8'h0C
`define BPPS_ADDR_DCC 8'h10
`define BPPS_ADDR_STATUS 8'h14
`define BPPS_ADDR_SET_A0 8'h18
`define BPPS_ADDR_SET_A1 8'h1C
`define BPPS_ADDR_SET_B 8'h20

// ==========================================================================
// Command word fields and codes
`define BPPS_CMD_CODE_HI 3
`define BPPS_CMD_CODE_LO 0
`define BPPS_CMD_PEC_OK_BIT 8
`define BPPS_DATA_PEC_OK_BIT 9
`define BPPS_CMD_START 4'h1
`define BPPS_CMD_WR_A 4'h2
`define BPPS_CMD_WR_B 4'h3
`define BPPS_CMD_CLEAR 4'h4
`define BPPS_CMD_MUTE 4'h5
`define BPPS_CMD_UNMUTE 4'h6
`define BPPS_CMD_POLL 4'h7

// ==========================================================================
// Status fields
`define BPPS_ST_BUSY_BIT 0
`define BPPS_ST_MUTE_BIT 1
`define BPPS_ST_POLL_BIT 2

// ==========================================================================
// Sizes and reset values
`define BPPS_NPINS 18
`define BPPS_SET_A_W 48
`define BPPS_SET_B_W 24
`define BPPS_SET_W 72
`define BPPS_SET_RST 72'h0
`define BPPS_RESP_OKAY 2'h0
`define BPPS_RESP_SLVERR 2'h2

// ==========================================================================
// Pulse timing
`define BPPS_CLK_NS 100
`define BPPS_PULSE_PERIOD_NS 155000
`define BPPS_PULSE_WIDTH_NS 77600
`define BPPS_PERIOD_CYC (`BPPS_PULSE_PERIOD_NS / `BPPS_CLK_NS)
`define BPPS_WIDTH_CYC \
  ((`BPPS_PULSE_WIDTH_NS + `BPPS_CLK_NS - 1) / `BPPS_CLK_NS)

`endif

/* File: logic/bpps_pkg.sv */
// Types shared by the balance pin pulse sequencer.
// Assumes nothing of its surroundings.
package bpps_pkg;

  // ========================================================================
  // Pulse sequencer states
  typedef enum logic {PS_IDLE, PS_RUN} bpps_state_e;

endpackage

/* File: logic/bpps_pulse_timer.sv */
// Pulse period timer for the balance pin sequencer.
// Assumes the owner raises run for a whole burst and drops it to restart.
`timescale 1ns/100ps
`default_nettype none
`include "bpps_defines.svh"

module bpps_pulse_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Control
  input wire logic run,
  // Timing outputs
  output logic pulse_hi,
  output logic period_end
);

  logic [10:0] phase_r;

  // ========================================================================
  // Phase counter, held at zero while idle
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || !run)
    begin
      phase_r <= 11'h000;
    end
    else if (phase_r == 11'(`BPPS_PERIOD_CYC - 1))
    begin
      phase_r <= 11'h000;
    end
    else
    begin
      phase_r <= phase_r + 11'h001;
    end
  end

  // Registered high phase and end-of-period strobe
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      pulse_hi <= 1'b0;
      period_end <= 1'b0;
    end
    else
    begin
      pulse_hi <= run && (phase_r < 11'(`BPPS_WIDTH_CYC));
      period_end <= run && (phase_r == 11'(`BPPS_PERIOD_CYC - 1));
    end
  end

endmodule
`default_nettype wire

/* File: logic/bpps_top.sv */
// Balance pin pulse sequencer: 18 pin settings, bursts, mute, poll.
// Assumes an AXI4-Lite master issuing commands with their check results.
//
// Operation
// - Each of 18 pins holds 4-bit setting: high, low, or 1-7 pulses.
// - Pulses repeat every 155 us, a rate of 6.45 kHz.
// - Each pulse stays high for 77.6 us.
// - Pulsing starts only after a start command whose check code matches.
// - Serial data out stays low until all pulse bursts are finished.
// - While pulsing, start and both settings writes are discarded.
// - The poll command reports whether pulsing has completed.
// - Good command but bad data check on settings write clears settings.
// - A set discharge bit forces its pin low over any setting.
// - Clear command zeroes settings and stops the pulsing machine.
// - Mute disables all pins, unmute re-enables; no data, no changes.
// - Muted state is readable as a read-only status bit.
// - Mute and unmute reach the pins two clocks after the command, far under 100 us.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "bpps_defines.svh"

module bpps_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Balance pins and poll data out
  output logic [17:0] bal_pin,
  output logic poll_sdo
);

  // ========================================================================
  // Declarations
  bpps_pkg::bpps_state_e state_r;
  logic [`BPPS_SET_W-1:0] set_r;
  logic [31:0] stg_a0_r;
  logic [15:0] stg_a1_r;
  logic [23:0] stg_b_r;
  logic [17:0] dcc_r;
  logic [2:0] rem_r [0:17];
  logic muted_r;
  logic poll_res_r;
  logic aw_got_r, w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [10:0] hi_len_r;
  logic [10:0] per_len_r;
  logic aw_hs, w_hs, ar_hs, do_wr, aw_got_nxt, w_got_nxt, bvalid_nxt;
  logic cmd_wr, cmd_ok, data_ok, busy, any_left;
  logic [3:0] cmd_code;
  logic tmr_hi, tmr_end;

  // ========================================================================
  // Helper functions
  // Burst length of a setting; codes with the top bit set never pulse
  function automatic logic [2:0] pulse_cnt(input logic [3:0] nib);
    pulse_cnt = nib[3] ? 3'h0 : nib[2:0];
  endfunction

  // Idle level of a pin when not pulsing
  function automatic logic static_lvl(input logic [3:0] nib);
    static_lvl = (nib == 4'h0);
  endfunction

  // Setting nibble of one pin
  function automatic logic [3:0] pin_nib(input logic [71:0] s,
                                         input int idx);
    pin_nib = s[idx*4 +: 4];
  endfunction

  // ========================================================================
  // Bus handshakes
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign do_wr = aw_got_r && w_got_r && !s_axi_bvalid;

  // Next values of the write channel flags
  always_comb
  begin
    aw_got_nxt = (aw_got_r || aw_hs) && !do_wr;
    w_got_nxt = (w_got_r || w_hs) && !do_wr;
    bvalid_nxt = do_wr || (s_axi_bvalid && !s_axi_bready);
  end

  // Write address and data capture, in either order
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      if (aw_hs)
      begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_hs)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      s_axi_awready <= !aw_got_nxt && !bvalid_nxt;
      s_axi_wready <= !w_got_nxt && !bvalid_nxt;
    end
  end

  // Write response; unmapped offsets answer with an error
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BPPS_RESP_OKAY;
    end
    else
    begin
      s_axi_bvalid <= bvalid_nxt;
      if (do_wr)
      begin
        case (awaddr_r)
          `BPPS_ADDR_CMD, `BPPS_ADDR_STG_A0, `BPPS_ADDR_STG_A1,
          `BPPS_ADDR_STG_B, `BPPS_ADDR_DCC:
            s_axi_bresp <= `BPPS_RESP_OKAY;
          default:
            s_axi_bresp <= `BPPS_RESP_SLVERR;
        endcase
      end
    end
  end

  // Staging words and discharge bits
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      stg_a0_r <= 32'h0000_0000;
      stg_a1_r <= 16'h0000;
      stg_b_r <= 24'h00_0000;
      dcc_r <= 18'h0_0000;
    end
    else if (do_wr && (&wstrb_r))
    begin
      case (awaddr_r)
        `BPPS_ADDR_STG_A0: stg_a0_r <= wdata_r;
        `BPPS_ADDR_STG_A1: stg_a1_r <= wdata_r[15:0];
        `BPPS_ADDR_STG_B: stg_b_r <= wdata_r[23:0];
        `BPPS_ADDR_DCC: dcc_r <= wdata_r[17:0];
        default: stg_b_r <= stg_b_r;
      endcase
    end
  end

  // ========================================================================
  // Command decode
  assign cmd_wr = do_wr && (awaddr_r == `BPPS_ADDR_CMD);
  assign cmd_code = wdata_r[`BPPS_CMD_CODE_HI:`BPPS_CMD_CODE_LO];
  assign cmd_ok = cmd_wr && wdata_r[`BPPS_CMD_PEC_OK_BIT];
  assign data_ok = wdata_r[`BPPS_DATA_PEC_OK_BIT];
  assign busy = (state_r == bpps_pkg::PS_RUN);

  // Pin settings store
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      set_r <= `BPPS_SET_RST;
    end
    else if (cmd_ok && cmd_code == `BPPS_CMD_CLEAR)
    begin
      set_r <= `BPPS_SET_RST;
    end
    else if (cmd_ok && !busy &&
             (cmd_code == `BPPS_CMD_WR_A || cmd_code == `BPPS_CMD_WR_B))
    begin
      if (!data_ok)
      begin
        set_r <= `BPPS_SET_RST;
      end
      else if (cmd_code == `BPPS_CMD_WR_A)
      begin
        set_r[`BPPS_SET_A_W-1:0] <= {stg_a1_r, stg_a0_r};
      end
      else
      begin
        set_r[`BPPS_SET_W-1:`BPPS_SET_A_W] <= stg_b_r;
      end
    end
  end

  // ========================================================================
  // Pulse sequencer
  always_comb
  begin
    any_left = 1'b0;
    for (int i = 0; i < `BPPS_NPINS; i++)
    begin
      if (rem_r[i] > 3'h1 || (rem_r[i] == 3'h1 && !tmr_end))
      begin
        any_left = 1'b1;
      end
    end
  end

  // Burst state: start, run, release
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state_r <= bpps_pkg::PS_IDLE;
    end
    else
    begin
      case (state_r)
        bpps_pkg::PS_IDLE:
          if (cmd_ok && cmd_code == `BPPS_CMD_START)
          begin
            state_r <= bpps_pkg::PS_RUN;
          end
        bpps_pkg::PS_RUN:
          if ((cmd_ok && cmd_code == `BPPS_CMD_CLEAR) || !any_left)
          begin
            state_r <= bpps_pkg::PS_IDLE;
          end
        default:
          state_r <= bpps_pkg::PS_IDLE;
      endcase
    end
  end

  // Remaining pulses per pin
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < `BPPS_NPINS; i++)
    begin
      if (!rstn || (cmd_ok && cmd_code == `BPPS_CMD_CLEAR))
      begin
        rem_r[i] <= 3'h0;
      end
      else if (!busy && cmd_ok && cmd_code == `BPPS_CMD_START)
      begin
        rem_r[i] <= pulse_cnt(pin_nib(set_r, i));
      end
      else if (busy && tmr_end && rem_r[i] != 3'h0)
      begin
        rem_r[i] <= rem_r[i] - 3'h1;
      end
    end
  end

  bpps_pulse_timer u_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .run(busy),
    .pulse_hi(tmr_hi),
    .period_end(tmr_end)
  );

  // Pin drivers
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < `BPPS_NPINS; i++)
    begin
      if (!rstn)
      begin
        bal_pin[i] <= 1'b0;
      end
      else if (muted_r || dcc_r[i])
      begin
        bal_pin[i] <= 1'b0;
      end
      else if (busy && rem_r[i] != 3'h0)
      begin
        bal_pin[i] <= tmr_hi;
      end
      else
      begin
        bal_pin[i] <= static_lvl(pin_nib(set_r, i));
      end
    end
  end

  // Mute flag, poll result and serial data out
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      muted_r <= 1'b0;
      poll_res_r <= 1'b0;
      poll_sdo <= 1'b1;
    end
    else
    begin
      if (cmd_ok && cmd_code == `BPPS_CMD_MUTE)
      begin
        muted_r <= 1'b1;
      end
      else if (cmd_ok && cmd_code == `BPPS_CMD_UNMUTE)
      begin
        muted_r <= 1'b0;
      end
      if (cmd_ok && cmd_code == `BPPS_CMD_POLL)
      begin
        poll_res_r <= !busy;
      end
      poll_sdo <= !busy;
    end
  end

  // ========================================================================
  // Read channel
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `BPPS_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !(ar_hs || (s_axi_rvalid && !s_axi_rready));
      if (ar_hs)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `BPPS_RESP_OKAY;
        case (s_axi_araddr)
          `BPPS_ADDR_STG_A0: s_axi_rdata <= stg_a0_r;
          `BPPS_ADDR_STG_A1: s_axi_rdata <= {16'h0000, stg_a1_r};
          `BPPS_ADDR_STG_B: s_axi_rdata <= {8'h00, stg_b_r};
          `BPPS_ADDR_DCC: s_axi_rdata <= {14'h0000, dcc_r};
          `BPPS_ADDR_STATUS: s_axi_rdata <= {29'h0000_0000, poll_res_r,
                                             muted_r, busy};
          `BPPS_ADDR_SET_A0: s_axi_rdata <= set_r[31:0];
          `BPPS_ADDR_SET_A1: s_axi_rdata <= {16'h0000, set_r[47:32]};
          `BPPS_ADDR_SET_B: s_axi_rdata <= {8'h00, set_r[71:48]};
          `BPPS_ADDR_CMD: s_axi_rdata <= 32'h0000_0000;
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `BPPS_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Checks
  // High-phase length counter for the width check
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || !tmr_hi)
    begin
      hi_len_r <= 11'h000;
    end
    else
    begin
      hi_len_r <= hi_len_r + 11'h001;
    end
  end

  // Period length counter for the rate check
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || !busy)
    begin
      per_len_r <= 11'h000;
    end
    else if (tmr_end)
    begin
      per_len_r <= 11'h001;
    end
    else
    begin
      per_len_r <= per_len_r + 11'h001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_width;
    $fell(tmr_hi) && busy |-> hi_len_r == 11'(`BPPS_WIDTH_CYC);
  endproperty
  a_width: assert property (p_width)
    else $error("pulse high time wrong");

  property p_period;
    busy && tmr_end |-> per_len_r == 11'(`BPPS_PERIOD_CYC);
  endproperty
  a_period: assert property (p_period)
    else $error("period strobes too close");

  property p_sdo_busy;
    busy |=> !poll_sdo;
  endproperty
  a_sdo_busy: assert property (p_sdo_busy)
    else $error("data out high while pulsing");

  property p_start_pec;
    !busy && cmd_wr && cmd_code == `BPPS_CMD_START && !cmd_ok |=> !busy;
  endproperty
  a_start_pec: assert property (p_start_pec)
    else $error("start taken with bad check");

  property p_busy_wr;
    busy && cmd_ok && cmd_code == `BPPS_CMD_WR_A |=> set_r == $past(set_r);
  endproperty
  a_busy_wr: assert property (p_busy_wr)
    else $error("settings changed while pulsing");

  property p_bad_data;
    !busy && cmd_ok && !data_ok &&
      (cmd_code == `BPPS_CMD_WR_A || cmd_code == `BPPS_CMD_WR_B)
      |=> set_r == `BPPS_SET_RST;
  endproperty
  a_bad_data: assert property (p_bad_data)
    else $error("bad data check did not clear");

  property p_clear;
    cmd_ok && cmd_code == `BPPS_CMD_CLEAR
      |=> !busy && set_r == `BPPS_SET_RST;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not release");

  property p_mute;
    cmd_ok && cmd_code == `BPPS_CMD_MUTE |=> muted_r ##1 bal_pin == 18'h0_0000;
  endproperty
  a_mute: assert property (p_mute)
    else $error("mute did not drop pins");

  property p_dcc;
    dcc_r != 18'h0_0000 |=> (bal_pin & $past(dcc_r)) == 18'h0_0000;
  endproperty
  a_dcc: assert property (p_dcc)
    else $error("discharge bit did not force low");

endmodule
`default_nettype wire

/* File: tb/bpps_conv_model.sv */
// Converter model: counts pulses and times them on every balance pin.
// Assumes the pins are registered levels on the system clock.
`timescale 1ns/100ps
`default_nettype none

module bpps_conv_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Observed pins and counter clear
  input wire logic [17:0] bal_pin,
  input wire logic clr,
  // Measurements per pin
  output logic [31:0] pulse_cnt [18],
  output logic [31:0] width_cyc [18],
  output logic [31:0] period_cyc [18]
);
  logic [17:0] pin_q;
  logic [31:0] hi_run [18];
  logic [31:0] gap_run [18];

  // ====================
  // Pulse edge counting
  // period and width seen
  always_ff @(posedge sys_clk)
  begin
    pin_q <= bal_pin;
    for (int i = 0; i < 18; i++)
    begin
      if (!rstn || clr)
      begin
        pulse_cnt[i] <= 32'h0;
        gap_run[i] <= 32'h0;
        hi_run[i] <= 32'h0;
      end
      else
      begin
        gap_run[i] <= gap_run[i] + 32'h1;
        hi_run[i] <= bal_pin[i] ? hi_run[i] + 32'h1 : 32'h0;
        if (bal_pin[i] && !pin_q[i])
        begin
          pulse_cnt[i] <= pulse_cnt[i] + 32'h1;
          period_cyc[i] <= gap_run[i];
          gap_run[i] <= 32'h1;
        end
        if (!bal_pin[i] && pin_q[i])
          width_cyc[i] <= hi_run[i];
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/balance_pin_pulse_sequencer_tb_top.sv */
// Testbench of the balance pin sequencer, driven over AXI4-Lite.
// Assumes the design header and the converter model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "bpps_defines.svh"

module balance_pin_pulse_sequencer_tb_top;
  localparam logic [31:0] pins_set = 32'h3E7F8;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1;
  logic s_axi_rready = 1'b1;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [17:0] bal_pin;
  logic poll_sdo;
  logic clr = 1'b0;
  logic [31:0] pulse_cnt [18];
  logic [31:0] width_cyc [18];
  logic [31:0] period_cyc [18];
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;

  // ====================
  // Design and converter
  bpps_top i_dut (.sys_clk(sys_clk), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .bal_pin(bal_pin),
    .poll_sdo(poll_sdo));
  bpps_conv_model i_conv (.sys_clk(sys_clk), .rstn(rstn),
    .bal_pin(bal_pin), .clr(clr), .pulse_cnt(pulse_cnt),
    .width_cyc(width_cyc), .period_cyc(period_cyc));

  // Clock and hang guard
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      miscompares++;
      end_sim();
    end
  end

  // ====================
  // Shared tasks
  task automatic end_sim();
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Write: offer address and data, release each on take
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic got;
    got = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!got)
    begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        got = 1'b1;
        rsp = s_axi_bresp;
      end
    end
  endtask

  // Read: hold request until taken, capture data
  task automatic rdx(input logic [7:0] a);
    logic got;
    got = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!got)
    begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        got = 1'b1;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
      end
    end
  endtask

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] exp);
    rdx(a);
    chk(nm, rd, exp);
  endtask

  task automatic cmd(input logic [3:0] c, input logic okc, okd);
    wr(`BPPS_ADDR_CMD, {22'h0, okd, okc, 4'h0, c});
  endtask

  // ====================
  // Scenarios
  task automatic t_reset();
    chk("pins", bal_pin, 32'h3FFFF);
    chk("sdo", poll_sdo, 32'h1);
    rc("status", `BPPS_ADDR_STATUS, 32'h0);
    chk("good_rresp", rsp, `BPPS_RESP_OKAY);
    rdx(8'h40);
    chk("bad_rresp", rsp, `BPPS_RESP_SLVERR);
    chk("bad_rdata", rd, 32'h0);
  endtask

  task automatic t_setup();
    wr(`BPPS_ADDR_DCC, 32'h0);
    chk("wr_bresp", rsp, `BPPS_RESP_OKAY);
    wr(`BPPS_ADDR_STG_A0, 32'h0F31);
    wr(`BPPS_ADDR_STG_A1, 32'h8000);
    wr(`BPPS_ADDR_STG_B, 32'h9);
    cmd(`BPPS_CMD_WR_A, 1'b1, 1'b1);
    cmd(`BPPS_CMD_WR_B, 1'b1, 1'b1);
    tick(3);
    rc("set_a0", `BPPS_ADDR_SET_A0, 32'h0F31);
    rc("set_a1", `BPPS_ADDR_SET_A1, 32'h8000);
    rc("set_b", `BPPS_ADDR_SET_B, 32'h9);
    chk("pins_set", bal_pin, pins_set);
  endtask

  task automatic t_dcc();
    wr(`BPPS_ADDR_DCC, 32'h8);
    tick(3);
    chk("dcc_pin", bal_pin, 32'h3E7F0);
    rc("dcc_reg", `BPPS_ADDR_DCC, 32'h8);
    s_axi_wstrb <= 4'h3;
    wr(`BPPS_ADDR_DCC, 32'h4);
    s_axi_wstrb <= 4'hF;
    rc("dcc_strb", `BPPS_ADDR_DCC, 32'h8);
    wr(`BPPS_ADDR_DCC, 32'h0);
    tick(3);
    chk("dcc_off", bal_pin, pins_set);
  endtask

  task automatic t_mute();
    cmd(`BPPS_CMD_MUTE, 1'b1, 1'b0);
    tick(3);
    chk("mute_pin", bal_pin, 32'h0);
    rc("mute_st", `BPPS_ADDR_STATUS, 32'h2);
    rc("mute_set", `BPPS_ADDR_SET_A0, 32'h0F31);
    cmd(`BPPS_CMD_UNMUTE, 1'b1, 1'b0);
    tick(3);
    chk("unmute_pin", bal_pin, pins_set);
    wr(`BPPS_ADDR_STATUS, 32'h2);
    chk("st_wr_resp", rsp, `BPPS_RESP_SLVERR);
    rc("st_ro", `BPPS_ADDR_STATUS, 32'h0);
  endtask

  task automatic t_burst();
    int n;
    cmd(`BPPS_CMD_START, 1'b0, 1'b1);
    tick(4);
    chk("no_start", poll_sdo, 32'h1);
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    cmd(`BPPS_CMD_START, 1'b1, 1'b0);
    tick(3);
    chk("sdo_busy", poll_sdo, 32'h0);
    wr(`BPPS_ADDR_STG_A0, 32'h0);
    cmd(`BPPS_CMD_WR_A, 1'b1, 1'b1);
    rc("locked", `BPPS_ADDR_SET_A0, 32'h0F31);
    cmd(`BPPS_CMD_POLL, 1'b1, 1'b0);
    rc("poll_busy", `BPPS_ADDR_STATUS, 32'h1);
    n = 0;
    while (poll_sdo !== 1'b1 && n < 6000)
    begin
      tick(1);
      n++;
    end
    chk("cnt0", pulse_cnt[0], 32'h1);
    chk("cnt1", pulse_cnt[1], 32'h3);
    chk("cnt2", pulse_cnt[2], 32'h0);
    chk("width", width_cyc[1], `BPPS_WIDTH_CYC);
    chk("period", period_cyc[1], `BPPS_PERIOD_CYC);
    chk("sdo_done", poll_sdo, 32'h1);
    chk("pins_end", bal_pin, pins_set);
    cmd(`BPPS_CMD_POLL, 1'b1, 1'b0);
    rc("poll_done", `BPPS_ADDR_STATUS, 32'h4);
  endtask

  task automatic t_badpec();
    wr(`BPPS_ADDR_STG_A0, 32'h7);
    cmd(`BPPS_CMD_WR_A, 1'b1, 1'b0);
    tick(3);
    rc("bad_a0", `BPPS_ADDR_SET_A0, 32'h0);
    rc("bad_b", `BPPS_ADDR_SET_B, 32'h0);
    chk("bad_pins", bal_pin, 32'h3FFFF);
  endtask

  task automatic t_clear();
    wr(`BPPS_ADDR_STG_A0, 32'h70);
    cmd(`BPPS_CMD_WR_A, 1'b1, 1'b1);
    cmd(`BPPS_CMD_START, 1'b1, 1'b0);
    tick(900);
    chk("mid_sdo", poll_sdo, 32'h0);
    cmd(`BPPS_CMD_CLEAR, 1'b1, 1'b0);
    tick(3);
    chk("clr_sdo", poll_sdo, 32'h1);
    rc("clr_a0", `BPPS_ADDR_SET_A0, 32'h0);
    chk("clr_pins", bal_pin, 32'h3FFFF);
  endtask

  // ====================
  // Main sequence
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    tick(2);
    t_reset();
    t_setup();
    t_dcc();
    t_mute();
    t_burst();
    t_badpec();
    t_clear();
    end_sim();
  end
endmodule
`default_nettype wire
